// ===== regbank_cfg.svh
`ifndef REGBANK_CFG_SVH
`define REGBANK_CFG_SVH
// address space bounds
`define ADDR_FIRST 16'h0000
`define ADDR_LAST 16'h1788
// commit strobe register and its trigger value
`define ADDR_COMMIT 16'h000f
`define COMMIT_VALUE 8'h01
// number of modelled storage slots and index width
`define SLOT_COUNT 16
`define SLOT_BITS 4
// zero byte returned on denied access
`define ZERO_BYTE 8'h00
`define OPT_NONE 16'h0000
`endif

// ===== regbank_pkg.sv
package regbank_pkg;
  // per-slot option flags
  typedef struct packed {
    logic readOnly;
    logic live;
    logic autoClear;
    logic excluded;
    logic lockDrop;
    logic refFault;
    logic loopUnlock;
    logic watchdogRestart;
    logic sysclkRestart;
    logic funcReassign;
    logic demapRefFault;
  } reg_opt_t;
  // bus owner
  typedef enum logic [1:0] {
    OWN_HOST = 2'b00,
    OWN_EEPROM = 2'b01
  } owner_t;
endpackage

// ===== shadowed_config_register_bank.sv
`timescale 1ns/100ps
`include "regbank_cfg.svh"
// How it works
// - addresses 0x0000 to 0x1788 are decoded, one byte each.
// - multi-byte parameters put their lsb at bit 0 of lowest address.
// - host writes go to buffered copy; writing 1 to commit copies all.
// - live registers take effect when their data byte completes.
// - ref-fault class write on selected ref gives one-cycle holdover at commit.
// - loop-unlock class write marks the loop unlocked until the next commit.
// - watchdog class write resets watchdog; counting resumes at commit.
// - stability class write resets timer; resumes at commit, only after lock.
// - reassign class write stops assigned function; new one starts at commit.
// - demap class acts like ref-fault class only in demapping mode.
// - autoclear bits act after commit and clear when action completes.
// - several classes on a register: every one of them applies.
// - denied or absent registers read zero and ignore writes.
// - host and eeprom never share regular registers; eeprom owns when active.
// - read-only registers always readable by host, never by eeprom.
// - excluded registers never move between bank and eeprom.
// - live read-only registers update continuously.
module shadowed_config_register_bank
  import regbank_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host serial port byte access
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [15:0] hostAddr,
  input wire logic [7:0] hostWdata,
  // eeprom controller byte access
  input wire logic eepromActive,
  input wire logic eepromWrite,
  input wire logic eepromRead,
  input wire logic [15:0] eepromAddr,
  input wire logic [7:0] eepromWdata,
  // device status inputs
  input wire logic [7:0] statusIn,
  input wire logic actionDone,
  input wire logic sysclkLocked,
  input wire logic demapMode,
  input wire logic funcAssigned,
  input wire logic [1:0] selectedRef,
  // outputs: registered read data
  output logic [7:0] hostRdata,
  output logic [7:0] eepromRdata,
  // active image, byte i is slot i
  output logic [8*`SLOT_COUNT-1:0] activeBytes,
  // side-effect levels and pulses
  output logic lockDetectEnable,
  output logic loopUnlocked,
  output logic refFaultHold,
  output logic watchdogRun,
  output logic stabilityRun,
  output logic funcRun,
  output logic commitPulse
);

  // ==========================================================
  // slot map: addresses 0x0000..0x000f are modelled slots
  // ==========================================================
  // option table: fixed per slot
  function automatic reg_opt_t slotOpt(input logic [`SLOT_BITS-1:0] idx);
    reg_opt_t o;
    o = reg_opt_t'(11'h000);
    case (idx)
      // interface configuration: live, kept out of eeprom
      4'h0, 4'h1: begin
        o.live = 1'b1;
        o.excluded = 1'b1;
      end
      // reserved byte kept out of eeprom
      4'h2: o.excluded = 1'b1;
      // identity and status bytes: read only, always current
      4'h3, 4'h4, 4'h5, 4'h6, 4'hb, 4'hc, 4'hd: begin
        o.readOnly = 1'b1;
        o.live = 1'b1;
      end
      // lock detector setting, restart on commit
      4'h7: o.lockDrop = 1'b1;
      // reference setting: holdover pulse and loop unlock
      4'h8: begin
        o.refFault = 1'b1;
        o.loopUnlock = 1'b1;
      end
      // timer settings: watchdog and stability restart
      4'h9: begin
        o.watchdogRestart = 1'b1;
        o.sysclkRestart = 1'b1;
      end
      // function assignment, also a demap reference setting
      4'ha: begin
        o.funcReassign = 1'b1;
        o.demapRefFault = 1'b1;
      end
      // one-shot action byte
      4'he: o.autoClear = 1'b1;
      // commit strobe itself
      4'hf: begin
        o.live = 1'b1;
        o.autoClear = 1'b1;
        o.excluded = 1'b1;
      end
      default: o = reg_opt_t'(11'h000);
    endcase
    return o;
  endfunction

  // ==========================================================
  // access decode and arbitration
  // ==========================================================
  wire logic hostInRange;
  wire logic eeInRange;
  wire logic [`SLOT_BITS-1:0] hostIdx;
  wire logic [`SLOT_BITS-1:0] eeIdx;
  wire reg_opt_t hostOpt;
  wire reg_opt_t eeOpt;
  wire logic hostSlot;
  wire logic eeSlot;
  wire logic hostWrOk;
  wire logic hostRdOk;
  wire logic eeWrOk;
  wire logic eeRdOk;
  wire logic commitHit;
  wire logic [1:0] slotRef;

  // only 0x0000..0x000f hold storage; rest of space reads zero
  assign hostInRange = (hostAddr <= `ADDR_LAST);
  assign eeInRange = (eepromAddr <= `ADDR_LAST);
  // slot index is the low address nibble; upper bits must be zero
  assign hostIdx = hostAddr[`SLOT_BITS-1:0];
  assign eeIdx = eepromAddr[`SLOT_BITS-1:0];
  assign hostSlot = hostInRange && (hostAddr[15:`SLOT_BITS] == 12'h000);
  assign eeSlot = eeInRange && (eepromAddr[15:`SLOT_BITS] == 12'h000);
  // fixed option flags of the addressed slot
  assign hostOpt = slotOpt(hostIdx);
  assign eeOpt = slotOpt(eeIdx);
  // read-only wins over regular access; eeprom owns regular regs when active
  assign hostWrOk = hostWrite && hostSlot && !hostOpt.readOnly
    && !eepromActive;
  assign hostRdOk = hostRead && hostSlot
    && (hostOpt.readOnly || !eepromActive);
  assign eeWrOk = eepromActive && eepromWrite && eeSlot && !eeOpt.readOnly
    && !eeOpt.excluded;
  assign eeRdOk = eepromActive && eepromRead && eeSlot && !eeOpt.readOnly
    && !eeOpt.excluded;
  // only the exact value one commits; any other byte just lands in slot f
  assign commitHit = hostWrOk && (hostAddr == `ADDR_COMMIT)
    && (hostWdata == `COMMIT_VALUE);

  // ==========================================================
  // buffered and active storage
  // ==========================================================
  // buffered copy takes writes; active copy is the one in use
  logic [8*`SLOT_COUNT-1:0] bufReg;
  logic [8*`SLOT_COUNT-1:0] actReg;
  wire logic [8*`SLOT_COUNT-1:0] bufNext;
  wire logic [8*`SLOT_COUNT-1:0] actNext;

  // low bits of the buffered slot 8 name the reference it belongs to
  assign slotRef = bufReg[8*8 +: 2];

  // one next-value path per slot; live and read-only slots skip the commit
  genvar gi;
  generate
    for (gi = 0; gi < `SLOT_COUNT; gi++) begin : g_slot
      localparam int GI = gi;
      localparam logic [`SLOT_BITS-1:0] IDX = GI[`SLOT_BITS-1:0];
      localparam reg_opt_t OPT = slotOpt(IDX);
      wire logic hostHit;
      wire logic eeHit;
      wire logic [7:0] wrByte;
      assign hostHit = hostWrOk && (hostIdx == IDX);
      assign eeHit = eeWrOk && (eeIdx == IDX);
      assign wrByte = eeHit ? eepromWdata : hostWdata;
      // read-only slots mirror status live; others hold written bytes
      assign bufNext[8*gi +: 8] = OPT.readOnly ? statusIn
        : (hostHit || eeHit) ? wrByte
        : (OPT.autoClear && actionDone) ? `ZERO_BYTE
        : bufReg[8*gi +: 8];
      // live slots follow at once; others copy together on commit
      assign actNext[8*gi +: 8] = (OPT.live || OPT.readOnly)
        ? bufNext[8*gi +: 8]
        : commitHit ? bufReg[8*gi +: 8]
        : (OPT.autoClear && actionDone) ? `ZERO_BYTE
        : actReg[8*gi +: 8];
    end
  endgenerate

  // byte storage, all slots at once
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bufReg <= '0;
      actReg <= '0;
    end else begin
      bufReg <= bufNext;
      actReg <= actNext;
    end
  end

  // ==========================================================
  // write-detect side effects
  // ==========================================================
  wire logic wrLockDrop;
  wire logic wrUnlock;
  wire logic wrRefFault;
  wire logic wrDemapFault;
  wire logic wrWatchdog;
  wire logic wrStability;
  wire logic wrReassign;
  wire logic refMatch;

  // only accepted host writes count; refused ones have no side effect
  // the written register must belong to the reference now in use
  assign refMatch = (slotRef == selectedRef);
  // lock detector classes
  assign wrLockDrop = hostWrOk && hostOpt.lockDrop;
  assign wrUnlock = hostWrOk && hostOpt.loopUnlock;
  // reference fault classes, the demap one gated by the loop mode
  assign wrRefFault = hostWrOk && hostOpt.refFault && refMatch;
  assign wrDemapFault = hostWrOk && hostOpt.demapRefFault && demapMode
    && refMatch;
  // timer and function classes
  assign wrWatchdog = hostWrOk && hostOpt.watchdogRestart;
  assign wrStability = hostWrOk && hostOpt.sysclkRestart;
  assign wrReassign = hostWrOk && hostOpt.funcReassign && funcAssigned;

  logic faultArmReg;
  logic stabPendReg;
  wire logic faultArmNext;
  wire logic stabPendNext;
  // a fault waits armed until the next commit; a new write re-arms it
  assign faultArmNext = (wrRefFault || wrDemapFault) ? 1'b1
    : commitHit ? 1'b0
    : faultArmReg;
  // a stability restart waits for a commit before the timer may run
  assign stabPendNext = wrStability ? 1'b1
    : (commitHit || (stabPendReg && stabilityRun)) ? 1'b0
    : stabPendReg;

  // side-effect state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      faultArmReg <= 1'b0;
      stabPendReg <= 1'b0;
      lockDetectEnable <= 1'b1;
      loopUnlocked <= 1'b0;
      refFaultHold <= 1'b0;
      watchdogRun <= 1'b1;
      stabilityRun <= 1'b0;
      funcRun <= 1'b1;
      commitPulse <= 1'b0;
    end else begin
      faultArmReg <= faultArmNext;
      stabPendReg <= stabPendNext;
      // one-cycle marker after each commit
      commitPulse <= commitHit;
      // write wins over a same-cycle commit
      lockDetectEnable <= wrLockDrop ? 1'b0
        : commitHit ? 1'b1 : lockDetectEnable;
      loopUnlocked <= (wrLockDrop || wrUnlock) ? 1'b1
        : commitHit ? 1'b0 : loopUnlocked;
      // holdover lasts exactly one cycle after the commit edge
      refFaultHold <= commitHit && faultArmReg;
      // watchdog stops on write and resumes on commit
      watchdogRun <= wrWatchdog ? 1'b0
        : commitHit ? 1'b1 : watchdogRun;
      // stability timer waits for commit and for system clock lock
      stabilityRun <= wrStability ? 1'b0
        : ((commitHit || !stabPendReg) && sysclkLocked) ? 1'b1
        : !sysclkLocked ? 1'b0 : stabilityRun;
      // assigned function stops on write, new one starts on commit
      funcRun <= wrReassign ? 1'b0
        : commitHit ? 1'b1 : funcRun;
    end
  end

  // ==========================================================
  // read data and active outputs
  // ==========================================================
  wire logic [7:0] hostByte;
  wire logic [7:0] eeByte;
  // host sees the active copy; eeprom saves and loads the buffered copy
  // refused reads give a zero byte
  assign hostByte = hostRdOk ? actReg[8*hostIdx +: 8] : `ZERO_BYTE;
  assign eeByte = eeRdOk ? bufReg[8*eeIdx +: 8] : `ZERO_BYTE;

  // registered read data and active image
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hostRdata <= `ZERO_BYTE;
      eepromRdata <= `ZERO_BYTE;
      activeBytes <= '0;
    end else begin
      hostRdata <= hostByte;
      eepromRdata <= eeByte;
      // image follows actNext so it equals actReg after every edge
      activeBytes <= actNext;
    end
  end

endmodule

// ===== regbank_assertions.sv
`timescale 1ns/100ps
// ====
// port checker for the register bank
module regbank_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [15:0] hostAddr,
  input wire logic [7:0] hostWdata,
  input wire logic eepromActive,
  input wire logic sysclkLocked,
  input wire logic funcAssigned,
  input wire logic [7:0] hostRdata,
  input wire logic lockDetectEnable,
  input wire logic loopUnlocked,
  input wire logic refFaultHold,
  input wire logic watchdogRun,
  input wire logic stabilityRun,
  input wire logic funcRun,
  input wire logic commitPulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // address of any host write while eeprom is inactive, all ones otherwise
  wire logic [15:0] wa = (hostWrite && !eepromActive) ? hostAddr : 16'hffff;
  commit_seen_a: assert property (
    wa == 16'h000f && hostWdata == 8'h01 |=> commitPulse)
    else $error("no commit pulse");
  lock_drop_a: assert property (wa == 16'h0007 |=> !lockDetectEnable)
    else $error("lock detect not dropped");
  lock_back_a: assert property ($rose(lockDetectEnable) |-> commitPulse)
    else $error("lock detect back without commit");
  loop_drop_a: assert property (wa == 16'h0008 |=> loopUnlocked)
    else $error("loop not unlocked");
  timer_stop_a: assert property (
    wa == 16'h0009 |=> !watchdogRun && !stabilityRun)
    else $error("timers not reset");
  stab_lock_a: assert property ($rose(stabilityRun) |-> $past(sysclkLocked))
    else $error("stability timer before lock");
  func_stop_a: assert property (wa == 16'h000a && funcAssigned |=> !funcRun)
    else $error("function not stopped");
  deny_read_a: assert property (hostRead && hostAddr > 16'h000f |=> hostRdata == 8'h00)
    else $error("absent register read nonzero");
  fault_once_a: assert property (refFaultHold |=> !refFaultHold)
    else $error("holdover longer than one cycle");
endmodule
bind shadowed_config_register_bank regbank_assertions u_regbank_assertions (.ref_clk, .sys_rst,
  .hostWrite, .hostRead, .hostAddr, .hostWdata, .eepromActive, .sysclkLocked, .funcAssigned,
  .hostRdata, .lockDetectEnable, .loopUnlocked, .refFaultHold, .watchdogRun, .stabilityRun,
  .funcRun, .commitPulse);

// ===== eeprom_ctrl_model.sv
`timescale 1ns/100ps
// ====
// eeprom controller model
module eeprom_ctrl_model (
  input wire logic ref_clk,
  input wire logic [7:0] eepromRdata,
  output logic eepromActive,
  output logic eepromWrite,
  output logic eepromRead,
  output logic [15:0] eepromAddr,
  output logic [7:0] eepromWdata
);
  // idle at time zero
  initial begin
    eepromActive = 1'b0;
    eepromWrite = 1'b0;
    eepromRead = 1'b0;
    eepromAddr = 16'h0000;
    eepromWdata = 8'h00;
  end
  // ownership level for an upload or download
  task own(input logic on);
    @(negedge ref_clk);
    eepromActive = on;
  endtask
  // one byte over one edge, read byte taken after it
  task xfer(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk);
    eepromWrite = wr;
    eepromRead = ~wr;
    eepromAddr = a;
    eepromWdata = d;
    @(negedge ref_clk);
    eepromWrite = 1'b0;
    eepromRead = 1'b0;
    q = eepromRdata;
    eepromAddr = ~a; // released bus shows no stale address
    eepromWdata = ~d;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
`include "regbank_cfg.svh"
// ====
// bench top
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hostWrite = 1'b0, hostRead = 1'b0, actionDone = 1'b0, sysclkLocked = 1'b0;
  logic demapMode = 1'b0, funcAssigned = 1'b1;
  logic [1:0] selectedRef = 2'b01;
  logic [15:0] hostAddr = 16'h0000;
  logic [7:0] hostWdata = 8'h00, statusIn = 8'h00;
  logic [7:0] hostRdata, eepromRdata, q, eepromWdata;
  logic eepromActive, eepromWrite, eepromRead, lockDetectEnable, loopUnlocked, refFaultHold;
  logic watchdogRun, stabilityRun, funcRun, commitPulse;
  logic [15:0] eepromAddr;
  logic [8*`SLOT_COUNT-1:0] activeBytes;
  int fail_count = 0, checks_done = 0, n;
  // clock
  always #50 ref_clk = ~ref_clk;
  shadowed_config_register_bank u_shadowed_config_register_bank (.ref_clk, .sys_rst, .hostWrite,
    .hostRead, .hostAddr, .hostWdata, .eepromActive, .eepromWrite, .eepromRead, .eepromAddr,
    .eepromWdata, .statusIn, .actionDone, .sysclkLocked, .demapMode, .funcAssigned, .selectedRef,
    .hostRdata, .eepromRdata, .activeBytes, .lockDetectEnable, .loopUnlocked, .refFaultHold,
    .watchdogRun, .stabilityRun, .funcRun, .commitPulse);
  eeprom_ctrl_model u_eeprom_ctrl_model (.ref_clk, .eepromRdata, .eepromActive, .eepromWrite,
    .eepromRead, .eepromAddr, .eepromWdata);
  // ====
  // helpers
  function automatic logic [7:0] act(input int i);
    return activeBytes[8*i +: 8];
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task hwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    hostWrite = 1'b1;
    hostAddr = a;
    hostWdata = d;
    @(negedge ref_clk);
    hostWrite = 1'b0;
  endtask
  task hrd(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    hostRead = 1'b1;
    hostAddr = a;
    @(negedge ref_clk);
    hostRead = 1'b0;
    chk(hostRdata, e);
  endtask
  task ee(input logic wr, input logic [15:0] a, input logic [7:0] d);
    u_eeprom_ctrl_model.xfer(wr, a, d, q);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ====
  // scenarios
  task t_commit;
    chk({lockDetectEnable, watchdogRun, funcRun, commitPulse, 4'h0}, 8'he0);
    hwr(16'h0007, 8'h5a);
    chk({7'h0, lockDetectEnable}, 8'h00);
    hwr(16'h0009, 8'h33);
    chk({7'h0, watchdogRun}, 8'h00);
    hwr(16'h000a, 8'h11);
    chk({7'h0, funcRun}, 8'h00);
    chk(act(7), 8'h00);
    hwr(16'h000f, 8'h01);
    chk({commitPulse, lockDetectEnable, watchdogRun, funcRun, 4'h0}, 8'hf0);
    chk(act(7), 8'h5a);
    chk(act(9), 8'h33);
    chk(act(10), 8'h11);
  endtask
  task t_stab;
    sysclkLocked = 1'b1;
    n = 0;
    while (stabilityRun !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h0, stabilityRun}, 8'h01);
    if (n == 8) complete_run;
    hwr(16'h0009, 8'h00);
    hwr(16'h000f, 8'h01);
    chk({6'h0, stabilityRun, watchdogRun}, 8'h03);
  endtask
  task t_live;
    hwr(16'h0000, 8'h3c);
    chk(act(0), 8'h3c);
    statusIn = 8'ha5;
    hrd(16'h0003, 8'ha5);
    hwr(16'h0004, 8'h00);
    hrd(16'h0004, 8'ha5);
    hwr(16'h1788, 8'hff);
    hrd(16'h1788, 8'h00);
  endtask
  task t_eeprom;
    u_eeprom_ctrl_model.own(1'b1);
    ee(1'b1, 16'h0007, 8'h77);
    hwr(16'h0007, 8'h01);
    ee(1'b0, 16'h0007, 8'h00);
    chk(q, 8'h77);
    hrd(16'h0007, 8'h00);
    hrd(16'h0005, 8'ha5);
    ee(1'b0, 16'h0005, 8'h00);
    chk(q, 8'h00);
    ee(1'b1, 16'h0002, 8'h44);
    ee(1'b0, 16'h0002, 8'h00);
    chk(q, 8'h00);
    u_eeprom_ctrl_model.own(1'b0);
    ee(1'b0, 16'h0007, 8'h00);
    chk(q, 8'h00);
  endtask
  // slot 8 names reference 0 before the first pass, so that pass gives no holdover
  task t_fault;
    for (int i = 0; i < 4; i++) begin
      demapMode = (i == 3);
      hwr(i < 2 ? 16'h0008 : 16'h000a, 8'h01);
      if (i == 0) chk({7'h0, loopUnlocked}, 8'h01);
      hwr(16'h000f, 8'h01);
      if (i == 0) chk({7'h0, loopUnlocked}, 8'h00);
      n = 0;
      repeat (3) begin
        n += int'(refFaultHold === 1'b1);
        @(negedge ref_clk);
      end
      chk(8'(n), (i == 1 || i == 3) ? 8'h01 : 8'h00);
    end
  endtask
  task t_autoclr;
    hwr(16'h000e, 8'h01);
    chk(act(14), 8'h00);
    hwr(16'h000f, 8'h01);
    chk(act(14), 8'h01);
    actionDone = 1'b1;
    @(negedge ref_clk);
    actionDone = 1'b0;
    chk(act(14), 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_commit;
    t_stab;
    t_live;
    t_eeprom;
    t_fault;
    t_autoclr;
    complete_run;
  end
endmodule
